/* verilog/tcr_pkg.sv */
// shared constants for the tributary config and pointer-loss registers
package tcr_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_UNIT = 3;
  localparam int NUM_GRP  = 7;
  localparam int NUM_TU   = 2;
  localparam int NUM_TRIB = NUM_UNIT * NUM_TU * NUM_GRP;
  localparam int NUM_FREG = NUM_UNIT * NUM_TU;

  // ----------------------------------------------------------------
  // register offsets, one entry per unit; one idle select offset shared by all units
  // ----------------------------------------------------------------
  localparam logic [7:0] TU2_CFG_OFS  [NUM_UNIT] = '{8'h28, 8'h48, 8'h68};
  localparam logic [7:0] TU2_FLAG_OFS [NUM_UNIT] = '{8'h2f, 8'h4f, 8'h6f};
  localparam logic [7:0] TU3_CFG_OFS  [NUM_UNIT] = '{8'h30, 8'h50, 8'h70};
  localparam logic [7:0] TU3_FLAG_OFS [NUM_UNIT] = '{8'h37, 8'h57, 8'h77};
  localparam logic [7:0] IDLE_SEL_OFS = 8'h80;

  // ----------------------------------------------------------------
  // config/status field positions and reset values
  // ----------------------------------------------------------------
  localparam int F_AIS   = 0;
  localparam int F_IDLE  = 1;
  localparam int F_FLAG_INVERT_DIAG  = 2;
  localparam int F_ALARM = 3;
  localparam int F_POINTER_LOST_STATE  = 4;
  localparam int F_PF    = 5;
  localparam logic       CTL_RST      = 1'b0;
  localparam logic [2:0] IDLE_SEL_RST = 3'h0;

  // ----------------------------------------------------------------
  // group configuration codes and byte patterns
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_ONE   = 2'h0;
  localparam logic [1:0] CFG_TWO   = 2'h1;
  localparam logic [1:0] CFG_THREE = 2'h2;
  localparam logic [1:0] CFG_FOUR  = 2'h3;
  localparam logic [7:0] ONES  = 8'hff;
  localparam logic [7:0] ZEROS = 8'h00;
endpackage

/* verilog/tcr_trib.sv */
// one tributary: control bits, pointer-loss flag and effective controls
`timescale 1ns/100ps
`default_nettype none
module tcr_trib
  import tcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cfg_wr,
  input  wire logic [7:0] wdata,
  input  wire logic       flag_clr,
  input  wire logic       active,
  input  wire logic       lop_state,
  input  wire logic       ais_state,
  input  wire logic       tu_just,
  input  wire logic       au_just,
  input  wire logic       depth_chg,
  output logic            pf,
  output logic            alarm_en,
  output logic            flag_invert_diag,
  output logic            idle,
  output logic            ais,
  output logic            flag,
  output logic            alarm_evt,
  output logic            ais_force,
  output logic            idle_force,
  output logic            ndf_invert,
  output logic            deadzone_collapse,
  output logic            just_req
);
  logic lop_prev;
  logic ais_prev;
  logic lop_chg;
  logic ais_chg;

  // ----------------------------------------------------------------
  // software control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pf       <= CTL_RST;
      alarm_en <= CTL_RST;
      flag_invert_diag     <= CTL_RST;
      idle     <= CTL_RST;
      ais      <= CTL_RST;
    end else if (cfg_wr) begin
      pf       <= wdata[F_PF];
      alarm_en <= wdata[F_ALARM];
      flag_invert_diag     <= wdata[F_FLAG_INVERT_DIAG];
      idle     <= wdata[F_IDLE];
      ais      <= wdata[F_AIS];
    end
  end

  // ----------------------------------------------------------------
  // state edge detection and sticky flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    lop_prev <= lop_state;
    ais_prev <= ais_state;
  end

  assign lop_chg = lop_state != lop_prev;
  assign ais_chg = ais_state != ais_prev;

  // set wins over the read clear; set regardless of alarm_en
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else begin
      flag <= (flag & ~flag_clr) | (lop_chg & active);
    end
  end

  // ----------------------------------------------------------------
  // effective controls toward datapath and pointer generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_force        <= 1'b0;
      ais_force         <= 1'b0;
      ndf_invert        <= 1'b0;
      deadzone_collapse <= 1'b0;
      just_req          <= 1'b0;
      alarm_evt         <= 1'b0;
    end else begin
      idle_force        <= active & idle;
      ais_force         <= active & ais & ~idle;
      ndf_invert        <= active & flag_invert_diag & ~(ais & ~idle);
      deadzone_collapse <= active & pf;
      // pointer requests ignore idle: pointer stays computed as normal
      just_req          <= active & pf & (tu_just | au_just | depth_chg);
      alarm_evt         <= active & alarm_en & (lop_chg | ais_chg);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_flag_on_change: assert property (
    active && $changed(lop_state) |=> flag)
    else $error("flag not set on pointer-loss change");
  a_flag_rd_clear: assert property (
    flag_clr && !(active && $changed(lop_state)) |=> !flag)
    else $error("flag not cleared by read");
  a_event_kept: assert property (
    flag_clr && active && $changed(lop_state) |=> flag)
    else $error("event lost in read-clear cycle");
  a_poll_masked: assert property (
    !alarm_en && active && $changed(lop_state) |=> flag && !alarm_evt)
    else $error("flag not kept for polling");
  a_ndf_vs_ais: assert property (
    ais_force |-> !ndf_invert)
    else $error("ndf inverted during ais insertion");
  a_idle_over_ais: assert property (
    active && idle && ais |=> idle_force && !ais_force)
    else $error("ais not overridden by idle");
  a_follow_just: assert property (
    active && pf && (tu_just || au_just) |=> just_req)
    else $error("no outgoing justification in follower mode");
  a_alarm_masked: assert property (
    !alarm_en |=> !alarm_evt)
    else $error("alarm event while masked");
endmodule
`default_nettype wire

/* verilog/tcr_regs.sv */
// tributary config/status and pointer-loss flag registers, three units
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// Functional notes
// - follower mode collapses dead-zone; each fill change requests justification
// - follower mode: each incoming or higher-order justification gives outgoing one
// - group config bits read-only, mirror the first-tributary register value
// - config 00 one, 01 two, 10 three, 11 four active tributaries
// - single large tributary mode: all second/third flags read zero
// - second-tributary flag reads zero in groups configured 00
// - third-tributary flag reads zero in groups configured 00 or 01
// - flag bits 0..6 are groups 1..7; bit 7 unused
// - flag set on pointer loss and on reacquisition
// - reading a flag register clears its flags right after the read
// - flags keep updating while alarm interrupt enable is low
// - third-tributary config has no effect in large mode or config 00/01
// - ais insertion forces all ones; idle insertion overrides it
// - idle replaces payload with idle code, v5 driven to zero
// - pointer still computed normally while idle is inserted
// - idle code zeros or ones by select; software keeps it low in large mode
// - diagnostic control inverts outgoing ndf, also alongside idle
// - ndf inversion ignored while ais insertion is in force
// - alarm enable gates events on loss-of-pointer and ais entry/exit
// - current pointer-loss state readable in the config/status register
// - group config ignored in single large tributary mode
// ------------------------------------------------------------------
module tcr_regs
  import tcr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic [7:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [7:0]              rdata,
  input  wire logic [NUM_UNIT-1:0]     tu3_mode,
  input  wire logic [NUM_UNIT*NUM_GRP*2-1:0] grp_cfg,
  input  wire logic [NUM_TRIB-1:0]     lop_state,
  input  wire logic [NUM_TRIB-1:0]     ais_state,
  input  wire logic [NUM_TRIB-1:0]     tu_just,
  input  wire logic [NUM_UNIT-1:0]     au_just,
  input  wire logic [NUM_TRIB-1:0]     depth_chg,
  input  wire logic [7:0]              byte_in,
  input  wire logic                    byte_valid,
  input  wire logic [1:0]              byte_unit,
  input  wire logic [2:0]              byte_grp,
  input  wire logic                    byte_tu,
  input  wire logic                    byte_is_v5,
  output logic      [7:0]              byte_out,
  output logic                         byte_out_valid,
  output logic      [NUM_TRIB-1:0]     ndf_invert,
  output logic      [NUM_TRIB-1:0]     deadzone_collapse,
  output logic      [NUM_TRIB-1:0]     just_req,
  output logic                         irq,
  output logic                         alarm_irq
);
  logic [NUM_TRIB-1:0] active;
  logic [NUM_TRIB-1:0] cfg_sel;
  logic [NUM_TRIB-1:0] pf;
  logic [NUM_TRIB-1:0] alarm_en;
  logic [NUM_TRIB-1:0] flag_invert_diag;
  logic [NUM_TRIB-1:0] idle;
  logic [NUM_TRIB-1:0] ais;
  logic [NUM_TRIB-1:0] flag;
  logic [NUM_TRIB-1:0] flag_vis;
  logic [NUM_TRIB-1:0] alarm_evt;
  logic [NUM_TRIB-1:0] ais_force;
  logic [NUM_TRIB-1:0] idle_force;
  logic [7:0]          cfg_rd [NUM_TRIB];
  logic [NUM_FREG-1:0] flag_sel;
  logic [NUM_UNIT-1:0] idle_pattern_sel;
  logic [7:0]          next_rdata;
  logic [7:0]          next_byte;
  logic [5:0]          bidx;
  logic                bidx_ok;
  logic                idle_sel_hit;

  // ------------------------------------------------------------------
  // per-tributary decode and state
  // ------------------------------------------------------------------
  for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
    for (genvar t = 0; t < NUM_TU; t++) begin : g_tu
      localparam int K = u * NUM_TU + t;
      localparam logic [7:0] FA = (t == 0) ? TU2_FLAG_OFS[u] : TU3_FLAG_OFS[u];
      assign flag_sel[K] = addr == FA;
      for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        localparam int I = K * NUM_GRP + g;
        localparam logic [7:0] CA = ((t == 0) ? TU2_CFG_OFS[u] : TU3_CFG_OFS[u]) + 8'(g);
        logic [1:0] cfg;
        logic       fits;
        assign cfg = grp_cfg[(u * NUM_GRP + g) * 2 +: 2];
        // second needs two or more, third needs three or more
        assign fits = (t == 0) ? (cfg != CFG_ONE) : (cfg >= CFG_THREE);
        assign active[I] = !tu3_mode[u] && fits;
        assign cfg_sel[I] = addr == CA;
        assign cfg_rd[I] = {cfg, pf[I], lop_state[I], alarm_en[I],
                            flag_invert_diag[I], idle[I], ais[I]};
        assign flag_vis[I] = flag[I] & active[I];

        tcr_trib u_trib (
          .clk               (clk),
          .srst              (srst),
          .cfg_wr            (wr_stb && cfg_sel[I]),
          .wdata             (wdata),
          .flag_clr          (rd_stb && flag_sel[K]),
          .active            (active[I]),
          .lop_state         (lop_state[I]),
          .ais_state         (ais_state[I]),
          .tu_just           (tu_just[I]),
          .au_just           (au_just[u]),
          .depth_chg         (depth_chg[I]),
          .pf                (pf[I]),
          .alarm_en          (alarm_en[I]),
          .flag_invert_diag              (flag_invert_diag[I]),
          .idle              (idle[I]),
          .ais               (ais[I]),
          .flag              (flag[I]),
          .alarm_evt         (alarm_evt[I]),
          .ais_force         (ais_force[I]),
          .idle_force        (idle_force[I]),
          .ndf_invert        (ndf_invert[I]),
          .deadzone_collapse (deadzone_collapse[I]),
          .just_req          (just_req[I])
        );
      end
    end
  end

  // ------------------------------------------------------------------
  // idle pattern select, one bit per unit
  // ------------------------------------------------------------------
  assign idle_sel_hit = addr == IDLE_SEL_OFS;

  always_ff @(posedge clk) begin
    if (srst) begin
      idle_pattern_sel <= IDLE_SEL_RST;
    end else if (wr_stb && idle_sel_hit) begin
      idle_pattern_sel <= wdata[NUM_UNIT-1:0];
    end
  end

  // ------------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ------------------------------------------------------------------
  always_comb begin
    next_rdata = ZEROS;
    for (int i = 0; i < NUM_TRIB; i++) begin
      if (cfg_sel[i]) begin
        next_rdata = cfg_rd[i];
      end
    end
    for (int k = 0; k < NUM_FREG; k++) begin
      if (flag_sel[k]) begin
        next_rdata = {1'b0, flag_vis[k*NUM_GRP +: NUM_GRP]};
      end
    end
    if (idle_sel_hit) begin
      next_rdata = {5'h00, idle_pattern_sel};
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= ZEROS;
    end else begin
      rdata <= rd_stb ? next_rdata : ZEROS;
    end
  end

  // ------------------------------------------------------------------
  // interrupt outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      irq       <= 1'b0;
      alarm_irq <= 1'b0;
    end else begin
      irq       <= |(flag_vis & alarm_en);
      alarm_irq <= |alarm_evt;
    end
  end

  // ------------------------------------------------------------------
  // payload byte override
  // ------------------------------------------------------------------
  assign bidx = 6'((int'(byte_unit) * NUM_TU + int'(byte_tu)) * NUM_GRP
                   + int'(byte_grp));
  assign bidx_ok = (int'(byte_unit) < NUM_UNIT) && (int'(byte_grp) < NUM_GRP);

  always_comb begin
    next_byte = byte_in;
    if (bidx_ok) begin
      if (idle_force[bidx]) begin
        if (byte_is_v5) begin
          next_byte = ZEROS;
        end else begin
          next_byte = idle_pattern_sel[byte_unit] ? ONES : ZEROS;
        end
      end else if (ais_force[bidx]) begin
        next_byte = ONES;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      byte_out       <= ZEROS;
      byte_out_valid <= 1'b0;
    end else begin
      byte_out_valid <= byte_valid;
      if (byte_valid) begin
        byte_out <= next_byte;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_irq_raise: assert property (
    |(flag_vis & alarm_en) |=> irq)
    else $error("irq not raised for enabled flag");
  a_irq_drop: assert property (
    !(|(flag_vis & alarm_en)) |=> !irq)
    else $error("irq high with no enabled flag");
  a_rdata_window: assert property (
    !rd_stb |=> rdata == ZEROS)
    else $error("read data outside read window");
  a_flag_bit7: assert property (
    rd_stb && |flag_sel |=> !rdata[7])
    else $error("flag register bit 7 not zero");
  a_cfg_mirror: assert property (
    rd_stb && cfg_sel[0] |=> rdata[7:6] == $past(grp_cfg[1:0]))
    else $error("group config not mirrored");
  a_pointer_lost_state_live: assert property (
    rd_stb && cfg_sel[0] |=> rdata[F_POINTER_LOST_STATE] == $past(lop_state[0]))
    else $error("pointer-loss state not reported");
  a_large_zero: assert property (
    rd_stb && tu3_mode[1] && (flag_sel[2] || flag_sel[3]) |=> rdata == ZEROS)
    else $error("flags not zero in large tributary mode");
  a_large_inactive: assert property (
    tu3_mode[1] |-> active[4*NUM_GRP-1:2*NUM_GRP] == '0)
    else $error("tributary active in large tributary mode");
  a_third_inactive: assert property (
    grp_cfg[5:4] == CFG_TWO |-> !active[NUM_GRP+2])
    else $error("third tributary active in two-tributary group");
  a_second_inactive: assert property (
    grp_cfg[1:0] == CFG_ONE |-> !active[0])
    else $error("second tributary active in one-tributary group");
  a_out_valid: assert property (
    byte_valid |=> byte_out_valid)
    else $error("byte lane valid not forwarded");
  a_pass_inactive: assert property (
    byte_valid && bidx_ok && !active[bidx] |=> byte_out == $past(byte_in))
    else $error("inactive tributary byte altered");
  a_v5_zero: assert property (
    byte_valid && byte_is_v5 && bidx_ok && idle_force[bidx]
    |=> byte_out == ZEROS)
    else $error("v5 not zero during idle");
  a_ais_ones: assert property (
    byte_valid && bidx_ok && ais_force[bidx] |=> byte_out == ONES)
    else $error("ais byte not all ones");

  c_rd_clear: cover property (rd_stb && |flag_sel ##1 rdata != ZEROS);
  c_idle_byte: cover property (byte_valid && bidx_ok && idle_force[bidx]);
  c_irq: cover property (!irq ##1 irq);
  c_follow_just: cover property (|just_req);
endmodule
`default_nettype wire

/* dv/tb_tcr_regs.sv */
// self-checking bench for the tributary config and pointer-loss registers
`timescale 1ns/100ps
`default_nettype none
module tb_tcr_regs;
  import tcr_pkg::*;
  logic                      clk, srst, wr_stb, rd_stb, rd_q, irq, alarm_irq;
  logic                      byte_valid, byte_tu, byte_is_v5, byte_out_valid;
  logic [7:0]                addr, wdata, rdata, byte_in, byte_out;
  logic [NUM_UNIT-1:0]       tu3_mode, au_just;
  logic [NUM_UNIT*NUM_GRP*2-1:0] grp_cfg;
  logic [NUM_TRIB-1:0]       lop_state, ais_state, tu_just, depth_chg;
  logic [NUM_TRIB-1:0]       ndf_invert, deadzone_collapse, just_req;
  logic [1:0]                byte_unit;
  logic [2:0]                byte_grp;
  logic [7:0]                rq[$], bq[$];
  int                        failures, n_tests, n_alarm, cyc, i;
  logic                      idl, ais, sel, pf;
  logic [7:0]                rb;

  tcr_regs u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .tu3_mode(tu3_mode), .grp_cfg(grp_cfg),
    .lop_state(lop_state), .ais_state(ais_state), .tu_just(tu_just), .au_just(au_just),
    .depth_chg(depth_chg), .byte_in(byte_in), .byte_valid(byte_valid),
    .byte_unit(byte_unit), .byte_grp(byte_grp), .byte_tu(byte_tu),
    .byte_is_v5(byte_is_v5), .byte_out(byte_out), .byte_out_valid(byte_out_valid),
    .ndf_invert(ndf_invert), .deadzone_collapse(deadzone_collapse),
    .just_req(just_req), .irq(irq), .alarm_irq(alarm_irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic act_f(int u, int t, int g);
    logic [1:0] c;
    c = grp_cfg[(u*7+g)*2+:2];
    return !tu3_mode[u] && ((t == 0) ? (c != CFG_ONE) : (c == CFG_THREE || c == CFG_FOUR));
  endfunction

  function automatic logic [7:0] fmask(int u, int t);
    logic [7:0] m;
    m = 8'h00;
    for (int g = 0; g < NUM_GRP; g++) m[g] = act_f(u, t, g);
    return m;
  endfunction

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask

  task automatic sb(input int u, input int g, input logic v5, input logic [7:0] b,
                    input logic [7:0] e);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_unit  <= 2'(u);
    byte_grp   <= 3'(g);
    byte_tu    <= 1'b1;
    byte_is_v5 <= v5;
    byte_in    <= b;
    bq.push_back(e);
    @(posedge clk);
    byte_valid <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // result monitor, alarm pulse count and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_q === 1'b1) cmp("rdata", rq.pop_front(), rdata);
    rd_q <= rd_stb;
    if (byte_out_valid === 1'b1) begin
      if (bq.size() == 0) cmp("byte_valid", 8'h00, 8'h01);
      else cmp("byte_out", bq.pop_front(), byte_out);
    end
    if (alarm_irq === 1'b1) n_alarm++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha51d));
    {srst, rd_q} = 2'b10;
    {wr_stb, rd_stb, byte_valid, byte_tu, byte_is_v5} = '0;
    {addr, wdata, byte_in, byte_unit, byte_grp} = '0;
    {lop_state, ais_state, tu_just, depth_chg, au_just} = '0;
    grp_cfg = 42'({$urandom(), $urandom()});
    grp_cfg[1:0] = CFG_FOUR;
    grp_cfg[5:4] = CFG_TWO;
    tu3_mode = 3'b010;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int u = 0; u < NUM_UNIT; u++) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        rd(TU2_CFG_OFS[u] + 8'(g), {grp_cfg[(u*7+g)*2+:2], 6'h00});
        rd(TU3_CFG_OFS[u] + 8'(g), {grp_cfg[(u*7+g)*2+:2], 6'h00});
      end
      rd(TU2_FLAG_OFS[u], 8'h00);
      rd(TU3_FLAG_OFS[u], 8'h00);
    end
    rd(8'hff, 8'h00);
    $display("reset and map test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lop_state <= ~lop_state;
      repeat (4) @(posedge clk);
      for (int u = 0; u < NUM_UNIT; u++) begin
        rd(TU2_FLAG_OFS[u], fmask(u, 0));
        rd(TU3_FLAG_OFS[u], fmask(u, 1));
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        rd(TU2_FLAG_OFS[u], 8'h00);
        rd(TU3_FLAG_OFS[u], 8'h00);
      end
      cmp("irq", 8'h00, {7'h00, irq});
    end
    cmp("alarm count", 8'h00, 8'(n_alarm));
    $display("flag test done");
    i = (0 * 2 + 1) * 7 + 0;
    wr(TU3_CFG_OFS[0], 8'hff);
    rd(TU3_CFG_OFS[0], 8'hef);
    wr(TU3_CFG_OFS[0], 8'h08);
    @(posedge clk);
    lop_state[i] <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("irq", 8'h01, {7'h00, irq});
    rd(TU3_CFG_OFS[0], 8'hd8);
    rd(TU3_FLAG_OFS[0], 8'h01);
    repeat (3) @(posedge clk);
    cmp("irq", 8'h00, {7'h00, irq});
    ais_state[i] <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("alarm count", 8'h02, 8'(n_alarm));
    @(posedge clk);
    addr         <= TU3_FLAG_OFS[0];
    rd_stb       <= 1'b1;
    lop_state[i] <= 1'b0;
    rq.push_back(8'h00);
    @(posedge clk);
    rd_stb <= 1'b0;
    repeat (3) @(posedge clk);
    rd(TU3_FLAG_OFS[0], 8'h01);
    $display("interrupt test done");
    wr(TU3_CFG_OFS[0] + 8'h02, 8'h03);
    wr(TU2_CFG_OFS[1], 8'h03);
    repeat (3) @(posedge clk);
    rb = 8'($urandom());
    sb(0, 2, 1'b0, rb, rb);
    sb(1, 0, 1'b0, 8'h5a, 8'h5a);
    for (int m = 0; m < 8; m++) begin
      {sel, ais, idl} = 3'(m);
      pf = idl ^ sel;
      wr(TU3_CFG_OFS[0], {2'b00, pf, 2'b00, 1'b1, idl, ais});
      wr(IDLE_SEL_OFS, {7'h00, sel});
      repeat (3) @(posedge clk);
      cmp("ndf_invert", 8'(!(ais && !idl)), 8'(ndf_invert[i]));
      cmp("deadzone", 8'(pf), 8'(deadzone_collapse[i]));
      @(posedge clk);
      if (m % 3 == 0) depth_chg[i] <= 1'b1;
      else if (m % 3 == 1) tu_just[i] <= 1'b1;
      else au_just[0] <= 1'b1;
      @(posedge clk);
      {depth_chg[i], tu_just[i], au_just[0]} <= 3'b000;
      #1;
      cmp("just_req", 8'(pf), 8'(just_req[i]));
      rb = 8'($urandom());
      sb(0, 0, 1'b0, rb, idl ? (sel ? ONES : ZEROS) : (ais ? ONES : rb));
      sb(0, 0, 1'b1, rb, idl ? ZEROS : (ais ? ONES : rb));
    end
    repeat (3) @(posedge clk);
    $display("insertion test done");
    complete_run();
  end
endmodule
`default_nettype wire
